//--- core/lxc_channel.sv
/*
 One integrating channel: counts converter pulses during an integration.
 Assumes pulse is already synchronised and clear is a one-cycle strobe.
*/
`timescale 1ns/1ps
module lxc_channel #(
	parameter int ACC_W = 17
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pulse,
	input wire logic clear,
	input wire logic low_gain,
	output logic [15:0] result
);
	import lxc_pkg::*;

	localparam logic [ACC_W-1:0] SAT = ACC_W'(int'(FULL_SCALE) + ACC_OFFSET);
	localparam logic [ACC_W-1:0] OFS = ACC_W'(ACC_OFFSET);

	generate
		if (ACC_W < 17) begin : g_bad_width
			$error("lxc_channel: ACC_W must hold full scale plus offset");
		end
	endgenerate

	logic [ACC_W-1:0] acc_reg;
	logic last_reg;
	logic [3:0] pre_reg;

	// A pulse counts only when the previous cycle did not count.
	wire take = pulse & ~last_reg & ~clear; // R2
	wire advance = take & (~low_gain | (pre_reg == GAIN_PRESCALE_TOP)); // R4
	wire at_sat = (acc_reg == SAT); // R3

	// Accumulator, spacing flag and low gain prescaler.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
			last_reg <= 1'b0;
			pre_reg <= 4'h0;
		end else if (clear) begin
			acc_reg <= '0;
			last_reg <= 1'b0;
			pre_reg <= 4'h0;
		end else begin
			last_reg <= take;
			if (take) begin
				pre_reg <= pre_reg + 4'h1;
			end
			if (advance && !at_sat) begin
				acc_reg <= acc_reg + 1'b1;
			end
		end
	end

	// The first two counts are the offset; the top is clamped at full scale.
	wire [ACC_W-1:0] net_count = acc_reg - OFS; // R2
	assign result = (acc_reg < OFS) ? 16'h0000 :
		(at_sat ? FULL_SCALE : net_count[15:0]); // R3
endmodule // lxc_channel

//--- core/lxc_pkg.sv
/*
 Shared constants and types of the two-channel light converter readout.
 Assumes a 125 MHz core clock that also stands in for the internal oscillator.
*/
// Functional notes
// (R1) Timing field 00/01/10 selects 11/81/322 groups of 918 oscillator cycles.
// (R2) Accumulator advances at most every second cycle and drops a two-count offset.
// (R3) Results saturate at 65535 in a 16-bit register.
// (R4) Low gain setting counts one sixteenth of the high gain rate.
// (R5) Both channels integrate together and each result lands in its own register.
// (R6) Data transfer is double buffered so a read never sees a half update.
// (R7) The next integration starts on its own after the transfer.
// (R8) Serial slave port uses SMBus and I2C Fast-Mode framing.
// (R9) Three-level strap picks slave address 0101001, 0111001 or 1001001.
// (R10) The alert response address 0001100 is always answered.
// (R11) The master appends a read/write bit after the seven address bits.
// (R12) In SMBus mode a line held low 25 to 35 ms is a timeout.
// (R13) A timeout abandons the transaction and returns the slave to idle.
// (R14) A byte with its top bit set is a command; low nibble selects the register.
// (R15) Results read as low/high bytes at Ch, Dh (broadband) and Eh, Fh (infrared).
package lxc_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_NS = 8;
	localparam int TOUT_MIN_US = 25000;
	localparam int TOUT_MAX_US = 35000;
	localparam int TOUT_CYC = (TOUT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int GROUP_LEN = 918;
	localparam logic [8:0] GROUPS_00 = 9'h00B;
	localparam logic [8:0] GROUPS_01 = 9'h051;
	localparam logic [8:0] GROUPS_10 = 9'h142;
	localparam logic [1:0] INTEG_SHORT = 2'h0;
	localparam logic [1:0] INTEG_MID = 2'h1;

	// ==========================================================
	// Conversion
	localparam logic [15:0] FULL_SCALE = 16'hFFFF;
	localparam int ACC_OFFSET = 2;
	localparam logic [3:0] GAIN_PRESCALE_TOP = 4'hF;

	// ==========================================================
	// Register map and fields
	localparam logic [3:0] REG_TIMING = 4'h1;
	localparam logic [3:0] REG_BB_LO = 4'hC;
	localparam logic [3:0] REG_BB_HI = 4'hD;
	localparam logic [3:0] REG_IR_LO = 4'hE;
	localparam logic [3:0] REG_IR_HI = 4'hF;
	localparam int INTEG_LSB = 0;
	localparam int GAIN_BIT = 4;
	localparam logic [7:0] TIMING_RST = 8'h02;
	localparam logic [7:0] CMD_RST = 8'h00;

	// ==========================================================
	// Slave addresses
	localparam logic [6:0] ADDR_GND = 7'h29;
	localparam logic [6:0] ADDR_FLOAT = 7'h39;
	localparam logic [6:0] ADDR_VDD = 7'h49;
	localparam logic [6:0] ADDR_ALERT = 7'h0C;

	// ==========================================================
	// Types
	typedef struct packed {
		logic cmd;
		logic clear;
		logic word;
		logic block;
		logic [3:0] addr;
	} lxc_cmd_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} lxc_pins_t;

endpackage

//--- core/lxc_readout.sv
/*
 Digital readout of a two-channel integrating light converter with a
 two-wire slave port. Holds the integration timer, both channels, the
 double-buffered result registers and the serial slave.
 Assumes scl, sda, strap and pulse inputs are asynchronous pins and
 that the bus wire is resolved outside from sda_oe (drive low when high).
*/
`timescale 1ns/1ps
module lxc_readout #(
	parameter int GROUP_CYC = lxc_pkg::GROUP_LEN,
	parameter int TOUT_CYCLES = lxc_pkg::TOUT_CYC,
	parameter bit SMBUS_MODE = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic sel_hi_i,
	input wire logic sel_lo_i,
	input wire logic bb_pulse_i,
	input wire logic ir_pulse_i,
	output logic conv_done
);
	import lxc_pkg::*;

	localparam int TW = $clog2(TOUT_CYCLES + 1);
	localparam logic [TW-1:0] TOUT_LAST = TW'(TOUT_CYCLES - 1);
	localparam logic [9:0] CYC_LAST = 10'(GROUP_CYC - 1);

	generate
		if (GROUP_CYC < 2 || GROUP_CYC > 1024 || TOUT_CYCLES < 2) begin : g_bad_param
			$error("lxc_readout: GROUP_CYC or TOUT_CYCLES out of range");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} lxc_state_t;

	// ==========================================================
	// Reset release
	logic [1:0] rst_sr_reg;

	// Reset asserts at once and releases after two clock edges.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sr_reg <= 2'b00;
		end else begin
			rst_sr_reg <= {rst_sr_reg[0], 1'b1};
		end
	end

	wire rst_n = rst_sr_reg[1];

	// ==========================================================
	// Input synchronisers
	logic [5:0] pins_s;
	lxc_pins_t line_now;
	lxc_pins_t line_prev_reg;

	lxc_sync #(
		.W(6),
		.RST_VAL(6'b11_0000)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({scl_i, sda_i, sel_hi_i, sel_lo_i, bb_pulse_i, ir_pulse_i}),
		.q(pins_s)
	);

	assign line_now = lxc_pins_t'(pins_s[5:4]);

	// Previous line levels for edge and condition detection.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_prev_reg <= 2'b11;
		end else begin
			line_prev_reg <= line_now;
		end
	end

	// Bus events seen on the synchronised lines.
	wire scl_rise = line_now.scl & ~line_prev_reg.scl;
	wire scl_fall = ~line_now.scl & line_prev_reg.scl;
	wire scl_hold = line_now.scl & line_prev_reg.scl;
	wire bus_start = scl_hold & line_prev_reg.sda & ~line_now.sda; // R8
	wire bus_stop = scl_hold & ~line_prev_reg.sda & line_now.sda; // R8

	// ==========================================================
	// Strap capture
	logic [1:0] strap_cnt_reg;
	logic [6:0] own_addr_reg;

	// The strap level is taken once, after the synchroniser has settled.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_reg <= 2'h0;
			own_addr_reg <= ADDR_FLOAT;
		end else if (strap_cnt_reg != 2'h3) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == 2'h2) begin
				own_addr_reg <= pins_s[3] ? ADDR_VDD : (pins_s[2] ? ADDR_GND : ADDR_FLOAT); // R9
			end
		end
	end

	// ==========================================================
	// Integration timer
	logic [7:0] timing_reg;
	logic [9:0] cyc_reg;
	logic [8:0] grp_reg;
	logic [1:0] integ_reg;
	logic gain_low_reg;
	logic conv_done_reg;

	// Group count chosen by the latched timing field.
	wire [8:0] grp_last = (integ_reg == INTEG_SHORT) ? GROUPS_00 - 9'h001 :
		((integ_reg == INTEG_MID) ? GROUPS_01 - 9'h001 : GROUPS_10 - 9'h001); // R1
	wire cyc_end = (cyc_reg == CYC_LAST);
	wire conv_end = cyc_end & (grp_reg == grp_last); // R1

	// Counts groups of oscillator cycles; wraps into the next integration.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_reg <= 10'h000;
			grp_reg <= 9'h000;
			integ_reg <= TIMING_RST[INTEG_LSB +: 2];
			gain_low_reg <= ~TIMING_RST[GAIN_BIT];
			conv_done_reg <= 1'b0;
		end else begin
			conv_done_reg <= conv_end;
			if (conv_end) begin
				cyc_reg <= 10'h000; // R7
				grp_reg <= 9'h000;
				integ_reg <= timing_reg[INTEG_LSB +: 2];
				gain_low_reg <= ~timing_reg[GAIN_BIT]; // R4
			end else if (cyc_end) begin
				cyc_reg <= 10'h000;
				grp_reg <= grp_reg + 9'h001;
			end else begin
				cyc_reg <= cyc_reg + 10'h001;
			end
		end
	end

	assign conv_done = conv_done_reg;

	// ==========================================================
	// Channels and double-buffered results
	lxc_cmd_t cmd_reg;
	logic [15:0] res [2];
	logic [15:0] data_reg [2];
	logic [7:0] hold_reg [2];
	logic lock_reg [2];
	logic tx_load;

	// Register select decode for the result bytes.
	wire data_sel = (cmd_reg.addr[3:2] == REG_BB_LO[3:2]); // R15
	wire data_ch = cmd_reg.addr[1]; // R15
	wire data_hi = cmd_reg.addr[0]; // R15

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			lxc_channel #(
				.ACC_W(17)
			) u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.pulse(pins_s[1 - g]),
				.clear(conv_end),
				.low_gain(gain_low_reg),
				.result(res[g])
			);

			wire lo_read = tx_load & data_sel & ~data_hi & (data_ch == 1'(g));
			wire hi_read = tx_load & data_sel & data_hi & (data_ch == 1'(g));

			// Whole words move at once; a low-byte read freezes the high byte.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					data_reg[g] <= 16'h0000;
					hold_reg[g] <= 8'h00;
					lock_reg[g] <= 1'b0;
				end else begin
					if (conv_end) begin
						data_reg[g] <= res[g]; // R5
					end
					if (lo_read) begin
						hold_reg[g] <= data_reg[g][15:8]; // R6
						lock_reg[g] <= 1'b1;
					end else if (hi_read) begin
						lock_reg[g] <= 1'b0;
					end else if (!lock_reg[g] && conv_end) begin
						hold_reg[g] <= res[g][15:8]; // R6
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Serial slave
	lxc_state_t state_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic rd_dir_reg;
	logic ara_reg;
	logic acked_reg;
	logic sda_oe_reg;
	logic [TW-1:0] tout_reg;

	// Address match and the byte handed to the master.
	wire byte_full = (bit_reg == 4'h8);
	wire ara_hit = (sh_reg[7:1] == ADDR_ALERT); // R10
	wire addr_hit = (sh_reg[7:1] == own_addr_reg) | ara_hit; // R9 R11
	wire [7:0] data_byte = data_hi ? hold_reg[data_ch] : data_reg[data_ch][7:0]; // R15
	wire [7:0] rd_byte = ara_reg ? {own_addr_reg, 1'b0} :
		(data_sel ? data_byte : ((cmd_reg.addr == REG_TIMING) ? timing_reg : 8'h00));
	wire wr_byte = (state_reg == ST_WR) & scl_fall & byte_full;
	wire tout_hit = SMBUS_MODE & (tout_reg == TOUT_LAST); // R12

	assign tx_load = scl_fall & (((state_reg == ST_ADDR_ACK) & rd_dir_reg) |
		((state_reg == ST_RD_ACK) & acked_reg));

	// Low-line timer, running only while a transaction is open.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tout_reg <= '0;
		end else if (state_reg == ST_IDLE || (line_now.scl && line_now.sda) || tout_hit) begin
			tout_reg <= '0;
		end else begin
			tout_reg <= tout_reg + 1'b1; // R12
		end
	end

	// Command and timing registers written from the bus.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= CMD_RST;
			timing_reg <= TIMING_RST;
		end else if (wr_byte && sh_reg[7]) begin
			cmd_reg <= {sh_reg[7], 1'b0, sh_reg[5:0]}; // R14
		end else if (wr_byte || tx_load) begin
			if (wr_byte && cmd_reg.addr == REG_TIMING) begin
				timing_reg <= sh_reg;
			end
			if (cmd_reg.word || cmd_reg.block) begin
				cmd_reg.addr <= cmd_reg.addr + 4'h1;
			end
		end
	end

	// Slave state machine; sda is only ever pulled low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rd_dir_reg <= 1'b0;
			ara_reg <= 1'b0;
			acked_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (tout_hit) begin
			state_reg <= ST_IDLE; // R13
			sda_oe_reg <= 1'b0;
		end else if (bus_start) begin
			state_reg <= ST_ADDR;
			bit_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR, ST_WR: begin
					if (scl_rise && !byte_full) begin
						sh_reg <= {sh_reg[6:0], line_now.sda};
						bit_reg <= bit_reg + 4'h1;
					end else if (scl_fall && byte_full) begin
						if (state_reg == ST_WR) begin
							sda_oe_reg <= 1'b1;
							state_reg <= ST_WR_ACK;
						end else if (addr_hit) begin
							sda_oe_reg <= 1'b1;
							rd_dir_reg <= sh_reg[0]; // R11
							ara_reg <= ara_hit;
							state_reg <= ST_ADDR_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						bit_reg <= 4'h0;
						if (rd_dir_reg) begin
							sh_reg <= rd_byte;
							sda_oe_reg <= ~rd_byte[7];
							state_reg <= ST_RD;
						end else begin
							sda_oe_reg <= 1'b0;
							state_reg <= ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bit_reg == 4'h7) begin
							sda_oe_reg <= 1'b0;
							state_reg <= ST_RD_ACK;
						end else begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							sda_oe_reg <= ~sh_reg[6];
							bit_reg <= bit_reg + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						acked_reg <= ~line_now.sda;
					end else if (scl_fall) begin
						if (acked_reg) begin
							bit_reg <= 4'h0;
							sh_reg <= rd_byte;
							sda_oe_reg <= ~rd_byte[7];
							state_reg <= ST_RD;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Open-drain data: the driven level is always low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe = sda_oe_reg;
endmodule // lxc_readout

//--- core/lxc_sync.sv
/*
 Two-flop synchroniser for a group of asynchronous inputs.
 Assumes the inputs are independent levels; no bus coherence is implied.
*/
`timescale 1ns/1ps
module lxc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import lxc_pkg::*;

	// Refuse an empty input group.
	generate
		if (W < 1) begin : g_bad_width
			$error("lxc_sync: W must be at least one");
		end
	endgenerate

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule // lxc_sync

//--- tb/lxc_master.sv
/*
 Bus master model: drives scl and pulls sda low towards the readout port.
 Assumes sda is the resolved wire with a pull-up.
*/
`timescale 1ns/1ps
module lxc_master (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// ==========================================================
	// Quarter period of the 125 ns link clock
	localparam realtime Q = 31.25;

	// The link clock stands high and sda is released while idle.
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// One bit: set sda in mid-low, sample it in mid-high.
	task automatic bit_x(input logic wb, output logic rb);
		sda_pull = !wb;
		#Q scl = 1'b1;
		#Q rb = sda;
		#Q scl = 1'b0;
		#Q;
	endtask

	// Start or repeated start: sda falls while scl is high.
	task automatic start();
		sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	// Stop: sda rises while scl is high.
	task automatic stop();
		sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#(2 * Q);
	endtask

	// Byte out, top bit first; ack is the slave's answer.
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask

	// Byte in; last gives a no-acknowledge to end the read.
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule // lxc_master

//--- tb/lxc_readout_chk.sv
/*
 Port checker of the light converter readout.
 Assumes it is bound to lxc_readout and sees only its ports.
*/
`timescale 1ns/1ps
module lxc_readout_chk
	import lxc_pkg::*;
#(
	parameter int GROUP_CYC = GROUP_LEN,
	parameter int TOUT_CYCLES = TOUT_CYC,
	parameter bit SMBUS_MODE = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic sel_hi_i,
	input wire logic sel_lo_i,
	input wire logic bb_pulse_i,
	input wire logic ir_pulse_i,
	input wire logic conv_done
);
	localparam int P0 = 11 * GROUP_CYC;
	localparam int P1 = 81 * GROUP_CYC;
	localparam int P2 = 322 * GROUP_CYC;
	int per_cnt;
	int low_cnt;
	logic seen;

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Counters of the conversion period and of low bus lines.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			per_cnt <= 0;
			low_cnt <= 0;
			seen <= 1'b0;
		end else begin
			per_cnt <= conv_done ? 0 : per_cnt + 1;
			low_cnt <= (scl_i && sda_i) ? 0 : low_cnt + 1;
			seen <= seen || conv_done;
		end
	end

	// Slave drive is already on as the master raises scl.
	sequence s_clk_up;
		$rose(scl_i) && sda_oe;
	endsequence

	// ==========================================================
	// Assertions
	a_sda_drive_low: assert property (sda_oe |-> sda_o == 1'b0)
		else $error("sda driven high");
	a_done_single: assert property (conv_done |=> !conv_done)
		else $error("done longer than one cycle");
	a_period_exact: assert property (conv_done && seen |-> (per_cnt + 1 == P0) ||
		(per_cnt + 1 == P1) || (per_cnt + 1 == P2))
		else $error("conversion period wrong");
	a_restart_bound: assert property (per_cnt < P2 + 8)
		else $error("next conversion did not start");
	a_change_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("sda drive changed with scl high");
	a_hold_scl_high: assert property (s_clk_up |-> sda_oe [*3])
		else $error("sda drive dropped with scl high");
	a_reset_quiet: assert property ($rose(nrst) |-> !sda_oe && !conv_done)
		else $error("outputs active in reset");
	a_timeout_release: assert property (SMBUS_MODE && low_cnt > TOUT_CYCLES + 16 |-> !sda_oe)
		else $error("bus not released after timeout");
endmodule // lxc_readout_chk

bind lxc_readout lxc_readout_chk #(.GROUP_CYC(GROUP_CYC), .TOUT_CYCLES(TOUT_CYCLES),
	.SMBUS_MODE(SMBUS_MODE)) chk_u (.clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .sel_hi_i(sel_hi_i), .sel_lo_i(sel_lo_i),
	.bb_pulse_i(bb_pulse_i), .ir_pulse_i(ir_pulse_i), .conv_done(conv_done));

//--- tb/tb_lxc_readout.sv
/*
 Self-checking bench of the light converter readout with a bus master model.
 Assumes the checker binds itself to the readout.
*/
`timescale 1ns/1ps
module tb_lxc_readout;
	import lxc_pkg::*;

	// ==========================================================
	// Short counts keep the run brief
	localparam int G = 4;
	localparam int TOUT = 400;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sel_hi = 1'b0;
	logic sel_lo = 1'b1;
	logic bb_p = 1'b1;
	logic ir_p = 1'b0;
	logic sda_o;
	logic sda_oe;
	logic conv_done;
	logic scl;
	logic m_pull;
	logic sda_w;
	logic [6:0] own = ADDR_GND;
	int fails = 0;
	int total_checks = 0;

	// Open-drain data wire with a pull-up.
	assign sda_w = !(sda_oe || m_pull);

	// Core clock of 8 ns.
	always #4 clk = ~clk;

	lxc_readout #(.GROUP_CYC(G), .TOUT_CYCLES(TOUT), .SMBUS_MODE(1'b1)) dut_u (
		.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .sel_hi_i(sel_hi), .sel_lo_i(sel_lo), .bb_pulse_i(bb_p),
		.ir_pulse_i(ir_p), .conv_done(conv_done));
	lxc_master m_u (.scl(scl), .sda_pull(m_pull), .sda(sda_w));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (12) @(posedge clk);
	endtask

	// Cycles until the next conversion pulse, bounded.
	task automatic wait_done(output int n);
		n = 0;
		while (conv_done !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 5000) begin
				fails++;
				$display("unexpected at %0t: no conversion", $time);
				end_of_test();
			end
		end
		@(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] d);
		logic a;
		m_u.start();
		m_u.wr({own, 1'b0}, a);
		m_u.wr(cmd, a);
		m_u.wr(d, a);
		m_u.stop();
	endtask

	task automatic rd_reg(input logic [7:0] cmd, input logic two, output logic [15:0] v);
		logic a;
		v = 16'h0000;
		m_u.start();
		m_u.wr({own, 1'b0}, a);
		m_u.wr(cmd, a);
		m_u.start();
		m_u.wr({own, 1'b1}, a);
		m_u.rd(!two, v[7:0]);
		if (two)
			m_u.rd(1'b1, v[15:8]);
		m_u.stop();
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_strap();
		logic [6:0] tbl [3] = '{ADDR_GND, ADDR_FLOAT, ADDR_VDD};
		logic a;
		logic [7:0] d;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			sel_lo <= (s == 0);
			sel_hi <= (s == 2);
			own = tbl[s];
			do_reset();
			m_u.start();
			m_u.wr({tbl[(s + 1) % 3], 1'b0}, a);
			m_u.stop();
			chk({15'h0000, a}, 16'h0000);
			m_u.start();
			m_u.wr({own, 1'b0}, a);
			m_u.stop();
			chk({15'h0000, a}, 16'h0001);
			m_u.start();
			m_u.wr({ADDR_ALERT, 1'b1}, a);
			m_u.rd(1'b1, d);
			m_u.stop();
			chk({15'h0000, a}, 16'h0001);
			chk({8'h00, d}, {8'h00, own, 1'b0});
		end
		$display("strap test done");
	endtask

	task automatic t_reg();
		logic [15:0] v;
		logic a;
		wr_reg(8'h81, 8'h12);
		rd_reg(8'h81, 1'b0, v);
		chk(v, 16'h0012);
		m_u.start();
		m_u.wr({own, 1'b0}, a);
		m_u.wr(8'h11, a);
		m_u.stop();
		rd_reg(8'h81, 1'b0, v);
		chk(v, 16'h0011);
		rd_reg(8'h87, 1'b0, v);
		chk(v, 16'h0000);
		$display("register test done");
	endtask

	// Set timing, measure one whole period, read both channels as words.
	task automatic t_conv(input logic [7:0] tim, input int per, input int lo, input int hi);
		logic [15:0] v;
		int n;
		wr_reg(8'h81, tim);
		wait_done(n);
		wait_done(n);
		wait_done(n);
		chk(16'(n + 1), 16'(per));
		rd_reg(8'hAC, 1'b1, v);
		chk({15'h0000, v >= 16'(lo) && v <= 16'(hi)}, 16'h0001);
		rd_reg(8'hAE, 1'b1, v);
		chk(v, 16'h0000);
		$display("conversion test done for timing %h", tim);
	endtask

	// Hold scl low during the address acknowledge until the port gives up.
	task automatic t_tout();
		logic r;
		logic a;
		m_u.start();
		for (int i = 6; i >= 0; i--) begin
			m_u.bit_x(own[i], r);
		end
		m_u.bit_x(1'b0, r);
		repeat (10) @(posedge clk);
		chk({15'h0000, sda_oe}, 16'h0001);
		repeat (TOUT - 50) @(posedge clk);
		chk({15'h0000, sda_oe}, 16'h0001);
		repeat (80) @(posedge clk);
		chk({15'h0000, sda_oe}, 16'h0000);
		m_u.bit_x(1'b1, r);
		m_u.wr(8'h81, a);
		m_u.stop();
		chk({15'h0000, a}, 16'h0000);
		m_u.start();
		m_u.wr({own, 1'b0}, a);
		m_u.stop();
		chk({15'h0000, a}, 16'h0001);
		$display("timeout test done");
	endtask

	// Main sequence.
	initial begin
		t_strap();
		t_reg();
		t_conv(8'h10, 11 * G, 11 * G / 2 - 2, 11 * G / 2 - 2);
		t_conv(8'h11, 81 * G, 81 * G / 2 - 2, 81 * G / 2 - 2);
		t_conv(8'h12, 322 * G, 322 * G / 2 - 2, 322 * G / 2 - 2);
		t_conv(8'h02, 322 * G, 322 * G / 32 - 2, 322 * G / 32 - 1);
		t_tout();
		end_of_test();
	end
endmodule // tb_lxc_readout
